/* File: rtl/pcm_defines.svh */
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define PCM_OFS_CONFIG     8'h54
`define PCM_OFS_STATUS     8'h55
`define PCM_OFS_FAULTS     8'h56
`define PCM_OFS_CMD        8'h57
`define PCM_OFS_DEBT       8'h58
`define PCM_OFS_FIXT_HI    8'h59
`define PCM_OFS_FIXT_LO    8'h5A
`define PCM_OFS_MINT       8'h5B
`define PCM_OFS_RELT_HI    8'h5C
`define PCM_OFS_RELT_LO    8'h5D
`define PCM_OFS_SLOPE_HI   8'h5E
`define PCM_OFS_SLOPE_LO   8'h5F

// ****************************************
// Reset values
// ****************************************
`define PCM_RST_CONFIG     8'h01
`define PCM_RST_CMD        8'h00
`define PCM_RST_DEBT       8'h05
`define PCM_RST_FIXT       16'h0320
`define PCM_RST_MINT       8'h03
`define PCM_RST_RELT       16'h0032
`define PCM_RST_SLOPE      16'h0040

// ****************************************
// Field positions and limits
// ****************************************
`define PCM_CMD_ACK        7
`define PCM_CMD_FLUSH      4
`define PCM_CMD_REGRST     3
`define PCM_CMD_FWCHK      2
`define PCM_CMD_CELLST     1
`define PCM_CMD_CONVST     0
`define PCM_CMD_MASK       8'h9F
`define PCM_CFG_MASK       8'h07
`define PCM_DEBT_BAD       8'hFF
`define PCM_DEBT_MAX       8'hFE
`define PCM_SLOPE_SHIFT    7

`endif

/* File: rtl/pcm_pkg.sv */
package pcm_pkg;

    // Sensor fault register layout, bit 7 down to bit 0
    typedef struct packed {
        logic converter_fault_flag;
        logic low_supply_warn_flag;
        logic pressure_over_flag;
        logic pressure_under_flag;
        logic temp_over_flag;
        logic temp_under_flag;
        logic volt_over_flag;
        logic volt_under_flag;
    } pcm_faults_t;

    // Pressure change part of the status register, bits 7..4
    typedef struct packed {
        logic host_notify_flag;
        logic slope_threshold_hit_flag;
        logic relative_threshold_hit_flag;
        logic fixed_threshold_hit_flag;
    } pcm_status_t;

    typedef enum logic [1:0] {
        PCM_COND_FIXED = 2'b00,
        PCM_COND_REL   = 2'b01,
        PCM_COND_SLOPE = 2'b10
    } pcm_cond_t;

endpackage

/* File: rtl/pcm_regs.sv */
`timescale 1ns/10ps
`include "pcm_defines.svh"
//
// Contract
// - Converter error sets fault bit 7
// - Low supply suspicion sets fault bit 6
// - Over/underflow flags in bits 5..0
// - Fault flags held until acknowledge completes
// - Acknowledge bit clears status and faults
// - Flush bit empties pressure queue, self-clears
// - Register reset bit restores RW defaults
// - Firmware check bit runs once, self-clears
// - Cell self-test bit runs once, self-clears
// - Converter self-test bit runs once, self-clears
// - Debounce limit 8 bits, reset 5
// - Debounce 255 becomes 254 after transfers
// - Fixed threshold 16 bits, reset 0x0320
// - Fixed flag when pressure stays above threshold
// - Rising means step at least minimum-rise count
// - Relative flag when rise stays above threshold
// - Slope flag when slope exceeds threshold
// - Slope is rise times 128 over periods+1
// - Config enables slope, relative, fixed; fixed default
// - New change flag sets notify and pulses pin
//
module pcm_regs (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 spi_seq_done,
    input  wire logic                 acq_done,
    input  wire pcm_pkg::pcm_faults_t acq_faults,
    input  wire logic                 sample_valid,
    input  wire logic [15:0]          sample_pressure,
    output pcm_pkg::pcm_status_t      change_status,
    output pcm_pkg::pcm_faults_t      fault_flags,
    output logic                      host_notify_pulse,
    output logic                      flush_queue_pulse,
    output logic                      fw_check_pulse,
    output logic                      cell_selftest_pulse,
    output logic                      conv_selftest_pulse
);

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0]           config_reg;
    logic [7:0]           cmd_reg;
    logic [7:0]           debt_reg;
    logic [15:0]          fixt_reg;
    logic [7:0]           mint_reg;
    logic [15:0]          relt_reg;
    logic [15:0]          slope_reg;
    pcm_pkg::pcm_faults_t faults_reg;
    pcm_pkg::pcm_status_t status_reg;
    logic [2:0]           hit_next;
    logic                 wr_cmd;
    logic                 seq_act;
    logic                 ack_go;
    logic                 regrst_go;

    assign wr_cmd    = reg_wr_en && (reg_addr == `PCM_OFS_CMD);
    // Commands run only once the host's transfer sequence has closed
    assign seq_act   = spi_seq_done && !wr_cmd;
    assign ack_go    = seq_act && cmd_reg[`PCM_CMD_ACK];
    assign regrst_go = seq_act && cmd_reg[`PCM_CMD_REGRST];

    always_ff @(posedge core_clk) begin
        if (sys_rst || regrst_go) begin
            config_reg <= `PCM_RST_CONFIG;
            debt_reg   <= `PCM_RST_DEBT;
            fixt_reg   <= `PCM_RST_FIXT;
            mint_reg   <= `PCM_RST_MINT;
            relt_reg   <= `PCM_RST_RELT;
            slope_reg  <= `PCM_RST_SLOPE;
        end else if (reg_wr_en) begin
            unique case (reg_addr)
                `PCM_OFS_CONFIG:   config_reg <= reg_wdata & `PCM_CFG_MASK;
                `PCM_OFS_DEBT:     debt_reg <= reg_wdata;
                `PCM_OFS_FIXT_HI:  fixt_reg[15:8] <= reg_wdata;
                `PCM_OFS_FIXT_LO:  fixt_reg[7:0] <= reg_wdata;
                `PCM_OFS_MINT:     mint_reg <= reg_wdata;
                `PCM_OFS_RELT_HI:  relt_reg[15:8] <= reg_wdata;
                `PCM_OFS_RELT_LO:  relt_reg[7:0] <= reg_wdata;
                `PCM_OFS_SLOPE_HI: slope_reg[15:8] <= reg_wdata;
                `PCM_OFS_SLOPE_LO: slope_reg[7:0] <= reg_wdata;
                default: ;
            endcase
        end else if (spi_seq_done && debt_reg == `PCM_DEBT_BAD) begin
            debt_reg <= `PCM_DEBT_MAX;
        end
    end

    // ****************************************
    // Command register and strobes
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd_reg <= `PCM_RST_CMD;
        end else if (wr_cmd) begin
            // Writing 0 leaves a pending command in place
            cmd_reg <= cmd_reg | (reg_wdata & `PCM_CMD_MASK);
        end else if (seq_act) begin
            cmd_reg <= `PCM_RST_CMD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flush_queue_pulse   <= 1'b0;
            fw_check_pulse      <= 1'b0;
            cell_selftest_pulse <= 1'b0;
            conv_selftest_pulse <= 1'b0;
        end else begin
            flush_queue_pulse   <= seq_act && cmd_reg[`PCM_CMD_FLUSH];
            fw_check_pulse      <= seq_act && cmd_reg[`PCM_CMD_FWCHK];
            cell_selftest_pulse <= seq_act && cmd_reg[`PCM_CMD_CELLST];
            conv_selftest_pulse <= seq_act && cmd_reg[`PCM_CMD_CONVST];
        end
    end

    // ****************************************
    // Sensor fault flags
    // ****************************************
    // A fault reported in the acknowledge cycle survives the clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            faults_reg <= '0;
        end else begin
            faults_reg <= (ack_go ? '0 : faults_reg)
                        | (acq_done ? acq_faults : '0);
        end
    end

    // ****************************************
    // Pressure change detection
    // ****************************************
    logic [15:0] prev_reg;
    logic        have_prev_reg;
    logic [15:0] base_reg;
    logic [7:0]  rise_cnt_reg;
    logic [7:0]  deb_cnt_reg [3];
    logic [16:0] step_need;
    logic        rising;
    logic [15:0] rise_base;
    logic [15:0] delta_p;
    logic [8:0]  periods;
    logic [22:0] slope_num;
    logic [22:0] slope_val;
    logic [2:0]  qual;

    assign step_need = {1'b0, prev_reg} + {9'h000, mint_reg};
    assign rising    = have_prev_reg && ({1'b0, sample_pressure} >= step_need);
    assign rise_base = (rise_cnt_reg == 8'h00) ? prev_reg : base_reg;
    assign delta_p   = rising ? (sample_pressure - rise_base) : 16'h0000;
    // Periods over which pressure has risen, this one included, plus one
    assign periods   = {1'b0, rise_cnt_reg} + 9'h002;
    assign slope_num = {delta_p, 7'h00};
    assign slope_val = slope_num / {14'h0000, periods};
    assign qual[pcm_pkg::PCM_COND_FIXED] = config_reg[0] && (sample_pressure > fixt_reg);
    assign qual[pcm_pkg::PCM_COND_REL]   = config_reg[1] && (delta_p > relt_reg);
    assign qual[pcm_pkg::PCM_COND_SLOPE] = config_reg[2]
                                          && (slope_val > {7'h00, slope_reg});

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_reg      <= 16'h0000;
            have_prev_reg <= 1'b0;
            base_reg      <= 16'h0000;
            rise_cnt_reg  <= 8'h00;
        end else if (sample_valid) begin
            prev_reg      <= sample_pressure;
            have_prev_reg <= 1'b1;
            if (rising) begin
                base_reg     <= rise_base;
                rise_cnt_reg <= (rise_cnt_reg == 8'hFF) ? 8'hFF : rise_cnt_reg + 8'h01;
            end else begin
                rise_cnt_reg <= 8'h00;
            end
        end
    end

    // One saturating debounce counter per condition
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_deb
            logic [7:0] cnt_next;
            assign cnt_next = (deb_cnt_reg[gi] == 8'hFF) ? 8'hFF : deb_cnt_reg[gi] + 8'h01;
            assign hit_next[gi] = sample_valid && qual[gi] && (cnt_next >= debt_reg);
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    deb_cnt_reg[gi] <= 8'h00;
                end else if (sample_valid) begin
                    deb_cnt_reg[gi] <= qual[gi] ? cnt_next : 8'h00;
                end
            end
        end
    endgenerate

    // ****************************************
    // Status flags and host notification
    // ****************************************
    logic [2:0] hit_now;
    logic       new_hit;

    assign hit_now = {status_reg.slope_threshold_hit_flag,
                      status_reg.relative_threshold_hit_flag,
                      status_reg.fixed_threshold_hit_flag};
    // Notify only on a flag that was clear or is being acknowledged now
    assign new_hit = |(hit_next & (ack_go ? 3'b111 : ~hit_now));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status_reg <= '0;
        end else begin
            status_reg <= (ack_go ? '0 : status_reg)
                        | {new_hit, hit_next};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            host_notify_pulse <= 1'b0;
        end else begin
            host_notify_pulse <= new_hit;
        end
    end

    assign change_status = status_reg;
    assign fault_flags   = faults_reg;

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                `PCM_OFS_CONFIG:   reg_rdata <= config_reg;
                `PCM_OFS_STATUS:   reg_rdata <= {status_reg, 4'h0};
                `PCM_OFS_FAULTS:   reg_rdata <= faults_reg;
                `PCM_OFS_CMD:      reg_rdata <= cmd_reg;
                `PCM_OFS_DEBT:     reg_rdata <= debt_reg;
                `PCM_OFS_FIXT_HI:  reg_rdata <= fixt_reg[15:8];
                `PCM_OFS_FIXT_LO:  reg_rdata <= fixt_reg[7:0];
                `PCM_OFS_MINT:     reg_rdata <= mint_reg;
                `PCM_OFS_RELT_HI:  reg_rdata <= relt_reg[15:8];
                `PCM_OFS_RELT_LO:  reg_rdata <= relt_reg[7:0];
                `PCM_OFS_SLOPE_HI: reg_rdata <= slope_reg[15:8];
                `PCM_OFS_SLOPE_LO: reg_rdata <= slope_reg[7:0];
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    fault_sticky_a: assert property (
        $past(faults_reg[7]) && !$past(ack_go) |-> faults_reg[7])
        else $error("fault flag dropped without acknowledge");
    fault_set_a: assert property (
        acq_done && acq_faults.converter_fault_flag |=> fault_flags.converter_fault_flag)
        else $error("converter fault not recorded");
    ack_clear_a: assert property (
        ack_go && !acq_done && !sample_valid |=> fault_flags == '0 && change_status == '0)
        else $error("acknowledge did not clear flags");
    cmd_self_a: assert property (
        seq_act && cmd_reg[`PCM_CMD_FWCHK] |=> fw_check_pulse && !cmd_reg[`PCM_CMD_FWCHK]
        ##1 !fw_check_pulse)
        else $error("firmware check strobe wrong");
    flush_once_a: assert property (
        flush_queue_pulse |-> $past(cmd_reg[`PCM_CMD_FLUSH]) && $past(spi_seq_done))
        else $error("flush without request");
    debt_clip_a: assert property (
        spi_seq_done && !reg_wr_en && !regrst_go && debt_reg == 8'hFF |=> debt_reg == 8'hFE)
        else $error("debounce limit not clipped");
    reg_reset_a: assert property (
        regrst_go |=> config_reg == 8'h01 && fixt_reg == 16'h0320 && slope_reg == 16'h0040)
        else $error("register reset incomplete");
    notify_link_a: assert property (
        host_notify_pulse |-> change_status.host_notify_flag && (hit_now != 3'b000))
        else $error("notify without change flag");
    fixed_off_a: assert property (
        !config_reg[0] && !change_status.fixed_threshold_hit_flag
        |=> !change_status.fixed_threshold_hit_flag)
        else $error("fixed flag raised while disabled");
    // First rising period divides by two, so the slope is the step times 64
    slope_calc_a: assert property (
        rising && rise_cnt_reg == 8'h00 |-> slope_val == {1'b0, delta_p, 6'h00})
        else $error("slope value wrong");

    notify_c: cover property (host_notify_pulse);
    ack_c:    cover property (ack_go && fault_flags != '0);
    slope_c:  cover property (hit_next[2]);
    regrst_c: cover property (regrst_go);

endmodule

/* File: tb/pcm_host_model.sv */
`timescale 1ns/10ps
// ****************************************
// Host side of the client link
// ****************************************
module pcm_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            spi_seq_done
);
    initial begin
        reg_wr_en    = 1'b0;
        reg_rd_en    = 1'b0;
        reg_addr     = 8'h00;
        reg_wdata    = 8'h00;
        spi_seq_done = 1'b0;
    end

    // Released lines show the inverse so a stale value is never taken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        d         = reg_rdata;
    endtask

    // Commands and flag clears only run once the sequence is closed here
    task automatic seq_end();
        @(negedge core_clk);
        spi_seq_done = 1'b1;
        @(negedge core_clk);
        spi_seq_done = 1'b0;
    endtask
endmodule

/* File: tb/pcm_regs_bench.sv */
`timescale 1ns/10ps
module pcm_regs_bench;
    logic                 core_clk;
    logic                 sys_rst;
    logic                 reg_wr_en;
    logic                 reg_rd_en;
    logic [7:0]           reg_addr;
    logic [7:0]           reg_wdata;
    logic [7:0]           reg_rdata;
    logic                 spi_seq_done;
    logic                 acq_done;
    pcm_pkg::pcm_faults_t acq_faults;
    logic                 sample_valid;
    logic [15:0]          sample_pressure;
    pcm_pkg::pcm_status_t change_status;
    pcm_pkg::pcm_faults_t fault_flags;
    logic                 host_notify_pulse;
    logic                 flush_queue_pulse;
    logic                 fw_check_pulse;
    logic                 cell_selftest_pulse;
    logic                 conv_selftest_pulse;
    logic [7:0]           rv;
    logic [3:0]           strb;
    int                   mismatches;
    int                   checks_done;

    pcm_regs i_pcm_regs (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .spi_seq_done(spi_seq_done), .acq_done(acq_done),
        .acq_faults(acq_faults), .sample_valid(sample_valid),
        .sample_pressure(sample_pressure), .change_status(change_status),
        .fault_flags(fault_flags), .host_notify_pulse(host_notify_pulse),
        .flush_queue_pulse(flush_queue_pulse), .fw_check_pulse(fw_check_pulse),
        .cell_selftest_pulse(cell_selftest_pulse),
        .conv_selftest_pulse(conv_selftest_pulse));

    pcm_host_model i_pcm_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .spi_seq_done(spi_seq_done));

    assign strb = {flush_queue_pulse, fw_check_pulse, cell_selftest_pulse, conv_selftest_pulse};

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        i_pcm_host_model.rd(a, rv);
        chk(nm, {8'h00, exp}, {8'h00, rv});
    endtask

    task automatic reset_dut();
        sys_rst = 1'b1;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
    endtask

    task automatic acq(input logic [7:0] f);
        @(negedge core_clk);
        acq_done   = 1'b1;
        acq_faults = f;
        @(negedge core_clk);
        acq_done   = 1'b0;
        acq_faults = ~f;
    endtask

    task automatic smp(input logic [15:0] p);
        @(negedge core_clk);
        sample_valid    = 1'b1;
        sample_pressure = p;
        @(negedge core_clk);
        sample_valid    = 1'b0;
        sample_pressure = ~p;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_values();
        logic [7:0] exp [13] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h05, 8'h03, 8'h20,
                                 8'h03, 8'h00, 8'h32, 8'h00, 8'h40, 8'h00};
        for (int i = 0; i < 13; i++) begin
            rdchk(8'h54 + 8'(i), exp[i], "reset value");
        end
    endtask

    task automatic test_faults();
        reset_dut();
        acq(8'hA5);
        chk("faults set", 16'h00A5, {8'h00, fault_flags});
        acq(8'h5A);
        chk("faults sticky", 16'h00FF, {8'h00, fault_flags});
        // The register is read-only, a write must not clear it
        i_pcm_host_model.wr(8'h56, 8'h00);
        i_pcm_host_model.seq_end();
        rdchk(8'h56, 8'hFF, "fault reg held");
        i_pcm_host_model.wr(8'h57, 8'h80);
        i_pcm_host_model.seq_end();
        chk("faults cleared", 16'h0000, {8'h00, fault_flags});
        rdchk(8'h57, 8'h00, "ack self clear");
    endtask

    task automatic test_commands();
        reset_dut();
        i_pcm_host_model.wr(8'h58, 8'h10);
        i_pcm_host_model.wr(8'h59, 8'h12);
        i_pcm_host_model.wr(8'h57, 8'h6F);
        i_pcm_host_model.wr(8'h57, 8'h00);
        rdchk(8'h57, 8'h0F, "cmd pending");
        i_pcm_host_model.wr(8'h57, 8'h10);
        i_pcm_host_model.seq_end();
        chk("strobes", 16'h000F, {12'h000, strb});
        @(negedge core_clk);
        chk("strobes end", 16'h0000, {12'h000, strb});
        rdchk(8'h57, 8'h00, "cmd cleared");
        rdchk(8'h58, 8'h05, "debt restored");
        rdchk(8'h59, 8'h03, "fixed hi restored");
    endtask

    task automatic test_debounce_clip();
        i_pcm_host_model.wr(8'h58, 8'hFF);
        i_pcm_host_model.seq_end();
        rdchk(8'h58, 8'hFE, "debt clipped");
    endtask

    // Three samples: no flag after the second, flag and one notify pulse after the third
    task automatic test_change(input logic [7:0] cfg, input logic [7:0] hi,
            input logic [15:0] thr, input logic [7:0] debt, input logic [15:0] p0,
            input logic [15:0] p1, input logic [15:0] p2, input logic [3:0] exp);
        reset_dut();
        i_pcm_host_model.wr(8'h54, cfg);
        i_pcm_host_model.wr(8'h58, debt);
        i_pcm_host_model.wr(hi, thr[15:8]);
        i_pcm_host_model.wr(hi + 8'h01, thr[7:0]);
        smp(p0);
        smp(p1);
        chk("change early", 16'h0000, {12'h000, change_status});
        smp(p2);
        chk("change flag", {12'h000, exp}, {12'h000, change_status});
        chk("notify pulse", 16'h0001, {15'h0000, host_notify_pulse});
        @(negedge core_clk);
        chk("notify one cycle", 16'h0000, {15'h0000, host_notify_pulse});
        i_pcm_host_model.wr(8'h57, 8'h80);
        i_pcm_host_model.seq_end();
        chk("status cleared", 16'h0000, {12'h000, change_status});
    endtask

    task automatic complete_run();
        $display("Mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        complete_run();
    end

    initial begin
        mismatches      = 0;
        checks_done     = 0;
        sys_rst         = 1'b1;
        acq_done        = 1'b0;
        acq_faults      = 8'h00;
        sample_valid    = 1'b0;
        sample_pressure = 16'h0000;
        reset_dut();
        test_reset_values();
        test_faults();
        test_commands();
        test_debounce_clip();
        // 0x7FFF would pass a signed compare against 0x8000
        test_change(8'h01, 8'h59, 16'h8000, 8'h02, 16'h7FFF, 16'h8001, 16'h8001,
            4'b1001);
        test_change(8'h02, 8'h5C, 16'h0005, 8'h01, 16'h0064, 16'h0067, 16'h006E,
            4'b1010);
        test_change(8'h04, 8'h5E, 16'h0100, 8'h01, 16'h0064, 16'h0068, 16'h006C,
            4'b1100);
        complete_run();
    end
endmodule
